// [ssu_defs.svh]
`ifndef SSU_DEFS_SVH
`define SSU_DEFS_SVH

// widths
`define SSU_DATA_W 8
`define SSU_CNT_W 4

// reset values and counter constants
`define SSU_SHIFT_RST 8'h00
`define SSU_CNT_RST 4'h0
`define SSU_CNT_MAX 4'hf
`define SSU_CNT_ACK 4'he

// wire mode codes
`define SSU_WM_OFF 2'h0
`define SSU_WM_THREE 2'h1
`define SSU_WM_TWO 2'h2
`define SSU_WM_TWO_HOLD 2'h3

// clock source codes
`define SSU_CS_SOFT 2'h0
`define SSU_CS_EXT_POS 2'h2
`define SSU_CS_EXT_NEG 2'h3

`endif

// [ssu_pkg.sv]
`include "ssu_defs.svh"

package ssu_pkg;

  typedef enum logic [1:0] {
    WIRE_OFF,
    WIRE_THREE,
    WIRE_TWO,
    WIRE_TWO_HOLD
  } ssu_wire_type;

  typedef enum logic [1:0] {
    CLK_SOFT,
    CLK_EXT_POS,
    CLK_EXT_NEG
  } ssu_clk_type;

  typedef struct packed {
    logic [1:0] wireMode;
    logic [1:0] clockSource;
    logic countByToggle;
  } ssu_ctrl_type;

  typedef struct packed {
    logic startFlag;
    logic overflowFlag;
    logic [`SSU_CNT_W-1:0] counter;
  } ssu_status_type;

endpackage

// [ssu_two_wire.sv]
`timescale 1ns/1ps
`include "ssu_defs.svh"

// Operation
// - software strobe shifts up to one bit per clock
// - two-wire protocol, no slew or filtering
// - master clocks; only slave holds clock
// - slave stretches clock by holding scl low
// - each serial clock edge increments counter with an external clock source and countByToggle clear
// - start detector sets start condition flag
// - hold scl low after start falling edge
// - shift sda in on the scl edge set by clock source
// - overflow after eight bits forces scl low in WIRE_TWO_HOLD mode only
// - direction bit decides who drives sda
// - bytes repeat until stop or repeated start
// - start detector active in two-wire mode only
module ssu_two_wire (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration
  input wire ssu_pkg::ssu_ctrl_type ctrl,
  // software strobes
  input wire logic shiftStrobe,
  input wire logic toggleStrobe,
  // register writes
  input wire logic dataLoad,
  input wire logic [`SSU_DATA_W-1:0] dataValue,
  input wire logic counterLoad,
  input wire logic [`SSU_CNT_W-1:0] counterValue,
  input wire logic startFlagClear,
  input wire logic overflowFlagClear,
  // port register bits
  input wire logic sdaPortBit,
  input wire logic sdaDirBit,
  input wire logic sclDirBit,
  // status
  output ssu_pkg::ssu_status_type status,
  output logic [`SSU_DATA_W-1:0] shiftData,
  // pins
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe_n,
  output logic dataOut
);

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic ssu_pkg::ssu_wire_type wireDecode(input logic [1:0] code);
    case (code)
      `SSU_WM_THREE: wireDecode = ssu_pkg::WIRE_THREE;
      `SSU_WM_TWO: wireDecode = ssu_pkg::WIRE_TWO;
      `SSU_WM_TWO_HOLD: wireDecode = ssu_pkg::WIRE_TWO_HOLD;
      default: wireDecode = ssu_pkg::WIRE_OFF;
    endcase
  endfunction

  function automatic ssu_pkg::ssu_clk_type clkDecode(input logic [1:0] code);
    case (code)
      `SSU_CS_EXT_POS: clkDecode = ssu_pkg::CLK_EXT_POS;
      `SSU_CS_EXT_NEG: clkDecode = ssu_pkg::CLK_EXT_NEG;
      default: clkDecode = ssu_pkg::CLK_SOFT;
    endcase
  endfunction

  ssu_pkg::ssu_wire_type wireMode;
  ssu_pkg::ssu_clk_type clkSrc;
  logic twoWire;
  logic holdMode;

  assign wireMode = wireDecode(ctrl.wireMode);
  assign clkSrc = clkDecode(ctrl.clockSource);
  assign twoWire = (wireMode == ssu_pkg::WIRE_TWO) || (wireMode == ssu_pkg::WIRE_TWO_HOLD);
  assign holdMode = (wireMode == ssu_pkg::WIRE_TWO_HOLD);

  // ----------------------------------------
  // pin synchronisers and edges
  // ----------------------------------------
  logic sdaMeta_reg;
  logic sdaSync_reg;
  logic sdaDly_reg;
  logic sclMeta_reg;
  logic sclSync_reg;
  logic sclDly_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sdaMeta_reg <= 1'b1;
      sdaSync_reg <= 1'b1;
      sdaDly_reg <= 1'b1;
      sclMeta_reg <= 1'b1;
      sclSync_reg <= 1'b1;
      sclDly_reg <= 1'b1;
    end else begin
      sdaMeta_reg <= sdaIn;
      sdaSync_reg <= sdaMeta_reg;
      sdaDly_reg <= sdaSync_reg;
      sclMeta_reg <= sclIn;
      sclSync_reg <= sclMeta_reg;
      sclDly_reg <= sclSync_reg;
    end
  end

  logic sclRise;
  logic sclFall;
  logic startSeen;

  assign sclRise = sclSync_reg && !sclDly_reg;
  assign sclFall = !sclSync_reg && sclDly_reg;
  // sda falling with scl high on both samples, so a data change
  // right after a clock fall is not mistaken for a start
  assign startSeen = twoWire && !sdaSync_reg && sdaDly_reg && sclSync_reg && sclDly_reg;

  // ----------------------------------------
  // shift and count enables
  // ----------------------------------------
  logic shiftEn;
  logic countEn;

  always_comb begin
    case (clkSrc)
      ssu_pkg::CLK_EXT_POS: shiftEn = sclRise;
      ssu_pkg::CLK_EXT_NEG: shiftEn = sclFall;
      default: shiftEn = shiftStrobe;
    endcase
  end

  always_comb begin
    if (clkSrc == ssu_pkg::CLK_SOFT) begin
      countEn = shiftStrobe;
    end else if (ctrl.countByToggle) begin
      countEn = toggleStrobe;
    end else begin
      countEn = sclRise || sclFall;
    end
  end

  // ----------------------------------------
  // shift register
  // ----------------------------------------
  logic [`SSU_DATA_W-1:0] shift_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_reg <= `SSU_SHIFT_RST;
    end else if (dataLoad) begin
      shift_reg <= dataValue;
    end else if (shiftEn) begin
      shift_reg <= {shift_reg[`SSU_DATA_W-2:0], sdaSync_reg};
    end
  end

  // ----------------------------------------
  // counter and flags
  // ----------------------------------------
  logic [`SSU_CNT_W-1:0] counter_reg;
  logic overflowNow;
  logic overflowFlag_reg;
  logic startFlag_reg;

  assign overflowNow = countEn && !counterLoad && (counter_reg == `SSU_CNT_MAX);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      counter_reg <= `SSU_CNT_RST;
    end else if (counterLoad) begin
      counter_reg <= counterValue;
    end else if (countEn) begin
      counter_reg <= counter_reg + 4'h1;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overflowFlag_reg <= 1'b0;
    end else if (overflowNow) begin
      overflowFlag_reg <= 1'b1;
    end else if (overflowFlagClear) begin
      overflowFlag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      startFlag_reg <= 1'b0;
    end else if (startSeen) begin
      startFlag_reg <= 1'b1;
    end else if (startFlagClear) begin
      startFlag_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // scl hold
  // ----------------------------------------
  // hold only engages on an scl fall, never yanks a high clock low
  logic holdWanted;
  logic hold_reg;

  assign holdWanted = twoWire && (startFlag_reg || (holdMode && (overflowFlag_reg || overflowNow)));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_reg <= 1'b0;
    end else if (!holdWanted) begin
      hold_reg <= 1'b0;
    end else if (sclFall) begin
      hold_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // clock port bit
  // ----------------------------------------
  logic sclPort_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclPort_reg <= 1'b1;
    end else if (toggleStrobe) begin
      sclPort_reg <= !sclPort_reg;
    end
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  logic sdaOut_next;
  logic sdaOe_n_next;
  logic sclOut_next;
  logic sclOe_n_next;

  always_comb begin
    if (twoWire) begin
      // open drain: released line floats high on the pull-up
      sdaOut_next = 1'b0;
      sdaOe_n_next = !(sdaDirBit && (!sdaPortBit || !shift_reg[`SSU_DATA_W-1]));
      sclOut_next = 1'b0;
      sclOe_n_next = !(sclDirBit && (!sclPort_reg || hold_reg));
    end else if (wireMode == ssu_pkg::WIRE_THREE) begin
      sdaOut_next = 1'b0;
      sdaOe_n_next = 1'b1;
      sclOut_next = sclPort_reg;
      sclOe_n_next = !sclDirBit;
    end else begin
      sdaOut_next = sdaPortBit;
      sdaOe_n_next = !sdaDirBit;
      sclOut_next = sclPort_reg;
      sclOe_n_next = !sclDirBit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sdaOut <= 1'b0;
      sdaOe_n <= 1'b1;
      sclOut <= 1'b0;
      sclOe_n <= 1'b1;
    end else begin
      sdaOut <= sdaOut_next;
      sdaOe_n <= sdaOe_n_next;
      sclOut <= sclOut_next;
      sclOe_n <= sclOe_n_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign dataOut = shift_reg[`SSU_DATA_W-1];
  assign shiftData = shift_reg;
  assign status = {startFlag_reg, overflowFlag_reg, counter_reg};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence startThenFall;
    twoWire && startFlag_reg && sclFall && !startFlagClear;
  endsequence

  sequence heldLow;
    hold_reg ##1 (sclOe_n == !sclDirBit);
  endsequence

  start_flag_set_a: assert property (startSeen |=> startFlag_reg)
    else $error("start seen but flag not set");

  start_mode_only_a: assert property ($rose(startFlag_reg) |-> $past(twoWire))
    else $error("start flag raised outside two-wire mode");

  count_step_a: assert property (countEn && !counterLoad
      |=> counter_reg == $past(counter_reg) + 4'h1)
    else $error("counter did not step on clock edge");

  overflow_flag_a: assert property (overflowNow
      |=> overflowFlag_reg && counter_reg == `SSU_CNT_RST)
    else $error("overflow not flagged after wrap");

  shift_in_a: assert property (shiftEn && !dataLoad
      |=> shift_reg == {$past(shift_reg[`SSU_DATA_W-2:0]), $past(sdaSync_reg)})
    else $error("shift register did not take sda");

  start_hold_a: assert property (startThenFall |=> heldLow)
    else $error("scl not held after start fall");

  hold_release_a: assert property (hold_reg && !holdWanted
      |=> !hold_reg ##1 (sclOe_n || !sclPort_reg))
    else $error("held clock not released");

  stretch_drive_a: assert property (twoWire && hold_reg && sclDirBit
      |=> !sclOe_n && !sclOut)
    else $error("stretch does not pull scl low");

  open_drain_a: assert property (twoWire |=> !sdaOut && !sclOut)
    else $error("bus line driven high");

endmodule

// [ssu_bus_master.sv]
`timescale 1ns/1ps
// ----------------
// two-wire master
// ----------------
module ssu_bus_master (
  // clock
  input wire logic clk,
  // wire levels
  input wire logic sdaWire,
  input wire logic sclWire,
  // pull-low requests
  output logic sdaPull,
  output logic sclPull
);
  initial begin
    sdaPull = 1'b0;
    sclPull = 1'b0;
  end
  task automatic waitCyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start;
    sdaPull = 1'b1;
    waitCyc(4);
    sclPull = 1'b1;
    waitCyc(4);
  endtask
  task automatic stop;
    sdaPull = 1'b1;
    waitCyc(4);
    sclPull = 1'b0;
    waitCyc(4);
    sdaPull = 1'b0;
    waitCyc(4);
  endtask
  // sda only moves well after the scl fall, the slave needs 2 clk to see it
  task automatic sendBit(input logic b, output logic seen);
    int i;
    waitCyc(2);
    sdaPull = ~b;
    waitCyc(2);
    sclPull = 1'b0;
    waitCyc(1);
    i = 0;
    while (!sclWire && i < 200) begin
      waitCyc(1);
      i++;
    end
    waitCyc(2);
    seen = sdaWire;
    waitCyc(2);
    sclPull = 1'b1;
  endtask
endmodule

// [test_serial_shift_two_wire.sv]
`timescale 1ns/1ps
`include "ssu_defs.svh"
module test_serial_shift_two_wire;
  logic clk, rst;
  ssu_pkg::ssu_ctrl_type ctrl;
  logic shiftStrobe, toggleStrobe, dataLoad, counterLoad, startFlagClear;
  logic overflowFlagClear, sdaPortBit, sdaDirBit, sclDirBit;
  logic [7:0] dataValue;
  logic [3:0] counterValue;
  ssu_pkg::ssu_status_type status;
  logic [7:0] shiftData;
  logic sdaOut, sdaOe_n, sclOut, sclOe_n, dataOut, sdaPull, sclPull, seen;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  // -----------
  // wiring
  // -----------
  // open-drain lines with pull-up: only pull-lows count
  wire sdaWire = ~(sdaPull | (~sdaOe_n & ~sdaOut));
  wire sclWire = ~(sclPull | (~sclOe_n & ~sclOut));
  ssu_two_wire uut (.clk(clk), .rst(rst), .ctrl(ctrl), .shiftStrobe(shiftStrobe),
    .toggleStrobe(toggleStrobe), .dataLoad(dataLoad), .dataValue(dataValue),
    .counterLoad(counterLoad), .counterValue(counterValue),
    .startFlagClear(startFlagClear), .overflowFlagClear(overflowFlagClear),
    .sdaPortBit(sdaPortBit), .sdaDirBit(sdaDirBit), .sclDirBit(sclDirBit),
    .status(status), .shiftData(shiftData), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n), .sclIn(sclWire), .sclOut(sclOut), .sclOe_n(sclOe_n),
    .dataOut(dataOut));
  ssu_bus_master bm (.clk(clk), .sdaWire(sdaWire), .sclWire(sclWire),
    .sdaPull(sdaPull), .sclPull(sclPull));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // -----------
  // helpers
  // -----------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic loadRegs(input logic [7:0] d, input logic [3:0] c);
    @(negedge clk);
    dataLoad = 1'b1;
    dataValue = d;
    counterLoad = 1'b1;
    counterValue = c;
    startFlagClear = 1'b1;
    overflowFlagClear = 1'b1;
    @(negedge clk);
    {dataLoad, counterLoad, startFlagClear, overflowFlagClear} = 4'h0;
  endtask
  // -----------
  // scenarios
  // -----------
  task automatic test_reset;
    check({2'h0, status}, 8'h00);
    check(shiftData, 8'h00);
    check({6'h0, sdaOe_n, sclOe_n}, 8'h03);
  endtask
  task automatic test_soft_shift;
    ctrl = '{wireMode: `SSU_WM_THREE, clockSource: `SSU_CS_SOFT, countByToggle: 1'b0};
    bm.start();
    bm.stop();
    check({7'h0, status.startFlag}, 8'h00);
    loadRegs(8'ha5, 4'h0);
    shiftStrobe = 1'b1;
    repeat (4) @(negedge clk);
    shiftStrobe = 1'b0;
    bm.waitCyc(2);
    check(shiftData, 8'h5f);
    check({4'h0, status.counter}, 8'h04);
    check({7'h0, dataOut}, 8'h00);
  endtask
  task automatic test_spi_slave;
    logic [7:0] spiByte = 8'h69;
    ctrl = '{wireMode: `SSU_WM_THREE, clockSource: `SSU_CS_EXT_POS, countByToggle: 1'b0};
    sclDirBit = 1'b0;
    bm.start();
    loadRegs(8'h96, 4'h0);
    check({7'h0, dataOut}, 8'h01);
    check({6'h0, sclOe_n, sdaOe_n}, 8'h03);
    for (int i = 7; i >= 0; i--) bm.sendBit(spiByte[i], seen);
    bm.waitCyc(6);
    check({2'h0, status}, 8'h10);
    check(shiftData, spiByte);
    bm.stop();
  endtask
  task automatic test_toggle_clock;
    ctrl = '{wireMode: `SSU_WM_THREE, clockSource: `SSU_CS_EXT_POS, countByToggle: 1'b1};
    sclDirBit = 1'b1;
    loadRegs(8'h00, 4'h0);
    toggleStrobe = 1'b1;
    @(negedge clk);
    toggleStrobe = 1'b0;
    bm.waitCyc(3);
    check({6'h0, sclOe_n, sclOut}, 8'h00);
    repeat (15) begin
      toggleStrobe = 1'b1;
      @(negedge clk);
      toggleStrobe = 1'b0;
      bm.waitCyc(3);
    end
    bm.waitCyc(4);
    check({2'h0, status}, 8'h10);
    check(shiftData, 8'hff);
    check({6'h0, dataOut, sclOut}, 8'h03);
  endtask
  task automatic test_two_wire;
    logic [7:0] addrByte = 8'h5a;
    logic [7:0] dataByte = 8'hc3;
    ctrl = '{wireMode: `SSU_WM_TWO_HOLD, clockSource: `SSU_CS_EXT_NEG,
      countByToggle: 1'b0};
    sclDirBit = 1'b1;
    loadRegs(8'hff, 4'h0);
    bm.start();
    bm.waitCyc(6);
    check({7'h0, status.startFlag}, 8'h01);
    check({6'h0, sclOe_n, sclOut}, 8'h00);
    loadRegs(8'hff, 4'h0);
    bm.waitCyc(4);
    check({7'h0, sclOe_n}, 8'h01);
    for (int i = 7; i >= 0; i--) bm.sendBit(addrByte[i], seen);
    bm.waitCyc(6);
    check({2'h0, status}, 8'h10);
    check(shiftData, 8'h5a);
    check({7'h0, sclOe_n}, 8'h00);
    sdaDirBit = 1'b1;
    sdaPortBit = 1'b0;
    loadRegs(8'hff, 4'he);
    bm.waitCyc(4);
    check({6'h0, sdaOe_n, sdaOut}, 8'h00);
    bm.sendBit(1'b1, seen);
    check({7'h0, seen}, 8'h00);
    bm.waitCyc(6);
    check({2'h0, status}, 8'h10);
    sdaDirBit = 1'b0;
    sdaPortBit = 1'b1;
    loadRegs(8'hff, 4'h0);
    for (int i = 7; i >= 0; i--) bm.sendBit(dataByte[i], seen);
    bm.waitCyc(6);
    check(shiftData, dataByte);
    loadRegs(8'hff, 4'he);
    bm.sendBit(1'b1, seen);
    check({7'h0, seen}, 8'h01);
    bm.waitCyc(6);
    check({2'h0, status}, 8'h10);
    sdaDirBit = 1'b0;
    loadRegs(8'hff, 4'h0);
    bm.stop();
  endtask
  task automatic test_two_wire_read;
    logic [7:0] addrByte = 8'h5b;
    logic [7:0] readByte = 8'h3c;
    bm.start();
    bm.waitCyc(6);
    check({7'h0, status.startFlag}, 8'h01);
    loadRegs(8'hff, 4'h0);
    for (int i = 7; i >= 0; i--) bm.sendBit(addrByte[i], seen);
    bm.waitCyc(6);
    check(shiftData, addrByte);
    sdaDirBit = 1'b1;
    sdaPortBit = 1'b0;
    loadRegs(8'hff, 4'he);
    bm.sendBit(1'b1, seen);
    check({7'h0, seen}, 8'h00);
    bm.waitCyc(6);
    sdaPortBit = 1'b1;
    loadRegs(readByte, 4'h0);
    for (int i = 7; i >= 0; i--) begin
      bm.sendBit(1'b1, seen);
      check({7'h0, seen}, {7'h0, readByte[i]});
    end
    bm.waitCyc(6);
    check({2'h0, status}, 8'h10);
    sdaDirBit = 1'b0;
    loadRegs(8'h00, 4'he);
    bm.sendBit(1'b1, seen);
    bm.waitCyc(6);
    check(shiftData, 8'h01);
    loadRegs(8'hff, 4'h0);
    bm.stop();
  endtask
  initial begin
    rst = 1'b1;
    ctrl = '0;
    {shiftStrobe, toggleStrobe, dataLoad, counterLoad} = 4'h0;
    {startFlagClear, overflowFlagClear, sdaDirBit, sclDirBit} = 4'h0;
    sdaPortBit = 1'b1;
    dataValue = 8'h00;
    counterValue = 4'h0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    test_reset();
    test_soft_shift();
    test_spi_slave();
    test_toggle_clock();
    test_two_wire();
    test_two_wire_read();
    give_verdict();
  end
endmodule
